// ==== core/adc_output_pkg.sv ====
// shared constants and types for the converter digital output block
package adc_output_pkg;
  localparam int          RESULT_W        = 8;
  localparam int          LEVEL_W         = 10;
  localparam int          LATENCY         = 5;
  localparam int          CODE_SPAN       = 256;
  localparam int          SYS_CLK_HZ      = 40000000;
  localparam int          STOP_TIME_US    = 100;
  localparam int          STOP_CYC        = (STOP_TIME_US * (SYS_CLK_HZ / 1000000));
  localparam int          WARM_CYCLES     = 20;
  localparam logic [11:0] STOP_CYC_12     = 12'(STOP_CYC);
  localparam logic [4:0]  WARM_CYCLES_5   = 5'(WARM_CYCLES);
  localparam logic [7:0]  CODE_ZERO       = 8'h00;
  localparam logic [7:0]  CODE_ONES       = 8'hFF;
  localparam logic        CLK_PREV_RESET  = 1'b0;

  typedef struct packed {
    logic                out_of_range_flag;
    logic [RESULT_W-1:0] code;
  } result_word_t;

  localparam result_word_t RESULT_RESET = '{out_of_range_flag: 1'b0, code: 8'h00};

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WARM = 2'b01,
    ST_RUN  = 2'b11
  } warm_state_t;
endpackage : adc_output_pkg

// ==== core/pipelined_adc_digital_output.sv ====
// pipelined converter output stage: sampling, five-fall latency, range flag, warm-up
//
// What this block does
// - result is eight-bit straight binary code
// - below range: flag high, code all zeros
// - above range: flag high, code all ones
// - in range: flag held low
// - track while clock high, capture on fall
// - result appears fifth fall later, holds one
// - every falling edge outside power-down starts a conversion
// - data invalid until 20 cycles after the clock restarts from a stop
// - power-down low disables bias and amplifiers
// - leaving power-down needs 20 cycles warm-up
`timescale 1ns/1ps
module pipelined_adc_digital_output
  import adc_output_pkg::*;
#(
  parameter int LAT = LATENCY
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  // converter inputs
  input  wire logic                              sampleClk,
  input  wire logic                              power_down_n,
  input  wire logic signed [LEVEL_W-1:0]         sampleLevel,
  // result and status outputs
  output adc_output_pkg::result_word_t           resultWord,
  output logic                                   dataValid,
  output logic                                   trackActive,
  output logic                                   biasEnable
);
  import adc_output_pkg::*;

  logic                clkPrev_reg;
  result_word_t        stage_reg [LAT];
  result_word_t        resultWord_reg;
  warm_state_t         state_reg;
  warm_state_t         state_next;
  logic [4:0]          warmCount_reg;
  logic [4:0]          warmCount_next;
  logic [11:0]         idleCount_reg;
  logic [11:0]         idleCount_next;

  wire                 fallEdge  = clkPrev_reg & ~sampleClk;
  wire                 anyEdge   = clkPrev_reg ^ sampleClk;
  wire                 convStep  = fallEdge & power_down_n;
  wire                 stopped   = (idleCount_reg == STOP_CYC_12);
  wire                 isUnder   = sampleLevel < 0;
  wire                 isOver    = sampleLevel > LEVEL_W'(CODE_SPAN - 1);
  result_word_t        captured;

  // quantiser result is clamped to the rails with the flag set on overflow
  wire [RESULT_W-1:0]  codeSel = isUnder ? CODE_ZERO
                       : isOver  ? CODE_ONES
                       : sampleLevel[RESULT_W-1:0];
  assign captured = '{out_of_range_flag: isUnder | isOver, code: codeSel};

  assign trackActive = sampleClk & power_down_n;
  assign biasEnable  = power_down_n;
  assign resultWord  = resultWord_reg;
  assign dataValid   = (state_reg == ST_RUN);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkPrev_reg <= CLK_PREV_RESET;
    end else begin
      clkPrev_reg <= sampleClk;
    end
  end

  // pipeline freezes in power-down so the last word stays on the outputs
  genvar g;
  generate
    for (g = 0; g < LAT; g++) begin : g_stage
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stage_reg[g] <= RESULT_RESET;
        end else if (convStep) begin
          stage_reg[g] <= (g == 0) ? captured : stage_reg[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resultWord_reg <= RESULT_RESET;
    end else if (convStep) begin
      resultWord_reg <= stage_reg[LAT-1];
    end
  end

  // a stalled or too-slow clock looks the same: no edge for the stop time
  assign idleCount_next = (!power_down_n || anyEdge) ? 12'h000
                        : stopped ? idleCount_reg
                        : idleCount_reg + 12'h001;

  assign warmCount_next = (!power_down_n || stopped || state_reg == ST_OFF) ? 5'h00
                        : (fallEdge && warmCount_reg != WARM_CYCLES_5)
                          ? warmCount_reg + 5'h01
                          : warmCount_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:  state_next = power_down_n ? ST_WARM : ST_OFF;
      ST_WARM: begin
        if (!power_down_n) begin
          state_next = ST_OFF;
        end else if (!stopped && warmCount_reg == WARM_CYCLES_5) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!power_down_n) begin
          state_next = ST_OFF;
        end else if (stopped) begin
          state_next = ST_WARM;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_OFF;
      warmCount_reg <= 5'h00;
      idleCount_reg <= 12'h000;
    end else begin
      state_reg     <= state_next;
      warmCount_reg <= warmCount_next;
      idleCount_reg <= idleCount_next;
    end
  end

  // checks
  a_code_inrange: assert property (@(posedge sys_clk) disable iff (rst)
    convStep && !isUnder && !isOver |=> stage_reg[0].code == $past(sampleLevel[7:0])
      && !stage_reg[0].out_of_range_flag)
    else $error("in-range code not captured as straight binary");

  a_under_zero: assert property (@(posedge sys_clk) disable iff (rst)
    convStep && isUnder |=> stage_reg[0].out_of_range_flag && stage_reg[0].code == 8'h00)
    else $error("underrange not flagged with zero code");

  a_over_ones: assert property (@(posedge sys_clk) disable iff (rst)
    convStep && isOver |=> stage_reg[0].out_of_range_flag && stage_reg[0].code == 8'hFF)
    else $error("overrange not flagged with all-ones code");

  a_flag_rails: assert property (@(posedge sys_clk) disable iff (rst)
    resultWord.out_of_range_flag |-> resultWord.code == 8'h00 || resultWord.code == 8'hFF)
    else $error("range flag set with an inner code");

  a_track_high: assert property (@(posedge sys_clk) disable iff (rst)
    trackActive |-> sampleClk && biasEnable)
    else $error("tracking outside clock-high phase");

  a_out_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(convStep) |-> $stable(resultWord))
    else $error("output changed without a falling edge");

  a_pipe_depth: assert property (@(posedge sys_clk) disable iff (rst)
    convStep |=> resultWord == $past(stage_reg[LAT-1]) && stage_reg[1] == $past(stage_reg[0]))
    else $error("pipeline did not advance on a falling edge");

  a_valid_warm: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(dataValid) |-> warmCount_reg == WARM_CYCLES_5 && $past(warmCount_reg) == WARM_CYCLES_5)
    else $error("data valid before twenty cycles");

  a_stop_invalid: assert property (@(posedge sys_clk) disable iff (rst)
    stopped && power_down_n |=> !dataValid && warmCount_reg == 5'h00)
    else $error("clock stop did not drop validity");

  a_pd_off: assert property (@(posedge sys_clk) disable iff (rst)
    !power_down_n |-> !biasEnable ##1 (!dataValid && $stable(resultWord)))
    else $error("power-down did not disable the converter");

  a_pd_rewarm: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(power_down_n) |-> ##[1:2] (state_reg == ST_WARM && warmCount_reg == 5'h00))
    else $error("leaving power-down skipped the warm-up");

  // warm-up and idle bookkeeping, plus pipeline, range and tracking checks
  a_warm_cap: assert property (@(posedge sys_clk) disable iff (rst)
    warmCount_reg <= WARM_CYCLES_5)
    else $error("warm-up count ran past its limit");

  a_idle_cap: assert property (@(posedge sys_clk) disable iff (rst)
    idleCount_reg <= STOP_CYC_12)
    else $error("idle count ran past the stop time");

  a_off_zero: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_OFF |-> warmCount_reg == 5'h00)
    else $error("warm-up count kept while off");

  a_pd_clear: assert property (@(posedge sys_clk) disable iff (rst)
    !power_down_n |=> warmCount_reg == 5'h00)
    else $error("power-down did not clear the warm-up count");

  a_pd_state: assert property (@(posedge sys_clk) disable iff (rst)
    !power_down_n |=> state_reg == ST_OFF)
    else $error("power-down did not reach the off state");

  a_run_count: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_RUN |-> warmCount_reg == WARM_CYCLES_5)
    else $error("running without a full warm-up count");

  a_warm_step: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != ST_OFF && power_down_n && !stopped && fallEdge && warmCount_reg != WARM_CYCLES_5
    |=> warmCount_reg == $past(warmCount_reg) + 5'h01)
    else $error("falling edge not counted during warm-up");

  a_warm_idle: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != ST_OFF && power_down_n && !stopped && !fallEdge |=> $stable(warmCount_reg))
    else $error("warm-up count moved without a falling edge");

  a_off_wake: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_OFF && power_down_n |=> state_reg == ST_WARM)
    else $error("power-up did not enter warm-up");

  a_idle_full: assert property (@(posedge sys_clk) disable iff (rst)
    power_down_n && !anyEdge && idleCount_reg == STOP_CYC_12 - 12'h001 |=> stopped)
    else $error("stop time reached without stop detection");

  a_edge_idle: assert property (@(posedge sys_clk) disable iff (rst)
    anyEdge || !power_down_n |=> idleCount_reg == 12'h000)
    else $error("clock edge did not restart the idle count");

  a_idle_step: assert property (@(posedge sys_clk) disable iff (rst)
    power_down_n && !anyEdge && !stopped |=> idleCount_reg == $past(idleCount_reg) + 12'h001)
    else $error("idle count did not advance");

  a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    power_down_n && !anyEdge && stopped |=> stopped)
    else $error("stop detection dropped without a clock edge");

  a_pd_stage: assert property (@(posedge sys_clk) disable iff (rst)
    !power_down_n |=> $stable(stage_reg[0]))
    else $error("pipeline captured during power-down");

  a_stage_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !convStep |=> $stable(stage_reg[LAT-1]))
    else $error("last stage moved without a falling edge");

  a_word_pair: assert property (@(posedge sys_clk) disable iff (rst)
    convStep |=> stage_reg[0] == $past(captured))
    else $error("flag and code not captured as one word");

  a_last_stage: assert property (@(posedge sys_clk) disable iff (rst)
    convStep |=> stage_reg[LAT-1] == $past(stage_reg[LAT-2]))
    else $error("last stage did not advance");

  a_fall_def: assert property (@(posedge sys_clk) disable iff (rst)
    fallEdge |-> !sampleClk && $past(sampleClk))
    else $error("falling edge seen without a high-to-low change");

  a_rise_warm: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(dataValid) |-> $past(state_reg) == ST_WARM)
    else $error("data valid without passing warm-up");

  a_stop_warm: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_RUN && stopped && power_down_n |=> state_reg == ST_WARM)
    else $error("clock stop did not restart warm-up");

  a_stop_novalid: assert property (@(posedge sys_clk) disable iff (rst)
    stopped |=> !dataValid)
    else $error("data valid while the clock is stopped");

  a_state_legal: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg inside {ST_OFF, ST_WARM, ST_RUN})
    else $error("warm-up state left its legal codes");

  a_run_stays: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_RUN && power_down_n && !stopped |=> dataValid)
    else $error("data valid dropped while running");

  a_warm_enter: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_WARM && power_down_n && !stopped && warmCount_reg == WARM_CYCLES_5
    |=> dataValid)
    else $error("full warm-up did not raise data valid");

  a_warm_wait: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_WARM && warmCount_reg != WARM_CYCLES_5 |=> !dataValid)
    else $error("data valid before warm-up completed");

  a_stage_rails: assert property (@(posedge sys_clk) disable iff (rst)
    stage_reg[0].out_of_range_flag |-> stage_reg[0].code == CODE_ZERO
      || stage_reg[0].code == CODE_ONES)
    else $error("captured flag set with an inner code");

  a_track_pd: assert property (@(posedge sys_clk) disable iff (rst)
    !power_down_n |-> !trackActive && !biasEnable)
    else $error("tracking or bias active in power-down");

  a_warm_clear: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_WARM && stopped |=> warmCount_reg == 5'h00 && state_reg != ST_RUN)
    else $error("stopped clock kept warm-up progress");

  c_reach_valid: cover property (@(posedge sys_clk) disable iff (rst) $rose(dataValid));
  c_overrange:   cover property (@(posedge sys_clk) disable iff (rst) convStep && isOver);
  c_underrange:  cover property (@(posedge sys_clk) disable iff (rst) convStep && isUnder);
  c_stop_rewarm: cover property (@(posedge sys_clk) disable iff (rst) dataValid ##1 stopped);
  c_pd_exit:     cover property (@(posedge sys_clk) disable iff (rst) $rose(power_down_n));
endmodule : pipelined_adc_digital_output

// ==== tb/capture_model.sv ====
// capture-side model: sample clock source and result word latch
`timescale 1ns/1ps
module capture_model (
  // clock and control
  input  wire logic                    sys_clk,
  input  wire logic                    run,
  input  wire logic                    power_down_n,
  // converter side
  input  wire adc_output_pkg::result_word_t resultWord,
  output logic                         sampleClk,
  output adc_output_pkg::result_word_t capWord
);
  import adc_output_pkg::*;
  initial sampleClk = 1'b0;
  initial capWord = RESULT_RESET;
  // 20 MHz, 25 ns phases; parked low when stopped or powered down
  always @(negedge sys_clk) sampleClk <= (run && power_down_n) ? ~sampleClk : 1'b0;
  // word taken whole at each sys_clk rise while the sample clock is low, so no bus activity mid-conversion
  always @(posedge sys_clk) if (!sampleClk) capWord <= resultWord;
endmodule : capture_model

// ==== tb/pipelined_adc_digital_output_test.sv ====
// testbench for the converter output stage
`timescale 1ns/1ps
module pipelined_adc_digital_output_test;
  import adc_output_pkg::*;
  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      run = 1'b0;
  logic                      power_down_n = 1'b1;
  logic signed [LEVEL_W-1:0] sampleLevel = 10'sh000;
  logic signed [LEVEL_W-1:0] prevLevel = 10'sh000;
  logic                      sampleClk;
  logic                      dataValid;
  logic                      trackActive;
  logic                      biasEnable;
  result_word_t              resultWord;
  result_word_t              capWord;
  int                        mismatches = 0;
  int                        n_compared = 0;
  logic signed [LEVEL_W-1:0] levels [6] = '{10'sh080, 10'sh000, 10'sh0FF, -10'sh001,
                                             10'sh100, 10'sh055};
  always #12.5 sys_clk = ~sys_clk;
  pipelined_adc_digital_output dut (
    .sys_clk(sys_clk), .rst(rst), .sampleClk(sampleClk), .power_down_n(power_down_n),
    .sampleLevel(sampleLevel), .resultWord(resultWord), .dataValid(dataValid),
    .trackActive(trackActive), .biasEnable(biasEnable));
  capture_model partner (.sys_clk(sys_clk), .run(run), .power_down_n(power_down_n),
    .resultWord(resultWord), .sampleClk(sampleClk), .capWord(capWord));
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bounded: a clock held high for eight sys_clk rises ends the run as a mismatch
  task automatic waitFalls(input int n);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i <= 8; i++) begin
        if (i == 8) begin
          mismatches++;
          give_verdict();
        end
        @(posedge sys_clk);
        #1;
        if (!sampleClk) break;
      end
    end
  endtask : waitFalls
  function automatic logic [8:0] expWord(input logic signed [LEVEL_W-1:0] lvl);
    if (lvl < 0) return {1'b1, CODE_ZERO};
    if (lvl > 10'sh0FF) return {1'b1, CODE_ONES};
    return {1'b0, lvl[7:0]};
  endfunction : expWord
  // margins of two falls either side of the exact warm-up count
  task automatic warmCheck;
    waitFalls(18);
    check("dataValid early", 9'h000, 9'(dataValid));
    waitFalls(4);
    check("dataValid late", 9'h001, 9'(dataValid));
  endtask : warmCheck
  // new level taken at the next fall; old word must still stand five falls on
  task automatic step(input logic signed [LEVEL_W-1:0] lvl, input logic [8:0] expOld);
    waitFalls(1);
    @(negedge sys_clk);
    sampleLevel = lvl;
    waitFalls(6);
    check("word at fifth fall", expOld, capWord);
    waitFalls(1);
    check("word after fifth fall", expWord(lvl), capWord);
  endtask : step
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    run <= 1'b1;
    warmCheck();
    @(negedge sys_clk);
    #1;
    check("trackActive high", 9'(sampleClk), 9'(trackActive));
    foreach (levels[i]) begin
      step(levels[i], expWord(prevLevel));
      prevLevel = levels[i];
    end
    @(negedge sys_clk);
    power_down_n <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("biasEnable", 9'h000, 9'(biasEnable));
    check("trackActive", 9'h000, 9'(trackActive));
    check("dataValid in power-down", 9'h000, 9'(dataValid));
    power_down_n <= 1'b1;
    warmCheck();
    @(negedge sys_clk);
    run <= 1'b0;
    repeat (4010) @(negedge sys_clk);
    check("dataValid after stop", 9'h000, 9'(dataValid));
    run <= 1'b1;
    warmCheck();
    give_verdict();
  end
endmodule : pipelined_adc_digital_output_test
